// ==== core/tmr_edge.sv ====
// tmr_edge: two-flop synchroniser and edge detector for one pin.
// assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module tmr_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  import tmr_pkg::*;

  tmr_edge_state_t st_reg, st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // edges look only at the second stage and its delayed copy
  assign rise = st_reg.s2 & ~st_reg.prev;
  assign fall = ~st_reg.s2 & st_reg.prev;

endmodule : tmr_edge
`default_nettype wire

// ==== core/tmr_prescale.sv ====
// tmr_prescale: free-running divider giving one-cycle ticks at /8, /64, /8192.
// assumes pclk is the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"

module tmr_prescale (
  input wire logic pclk,
  input wire logic presetn,
  output var logic tick8,
  output var logic tick64,
  output var logic tick8192
);
  import tmr_pkg::*;

  tmr_div_state_t st_reg, st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + `TMR_DIV_W'(1);
    st_next.t8 = (st_reg.cnt & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
    st_next.t64 = (st_reg.cnt & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
    st_next.t8192 = (st_reg.cnt & `TMR_DIV8192_MASK) == `TMR_DIV8192_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick8 = st_reg.t8;
  assign tick64 = st_reg.t64;
  assign tick8192 = st_reg.t8192;

endmodule : tmr_prescale
`default_nettype wire

// ==== core/tmr_top.sv ====
// tmr_top: four 8-bit timer channels in pairs 0/1 and 2/3 behind an APB slave.
// assumes APB with pstrb, pins synchronised here, pclk as system clock.
//
// Operation
// R01: eight-bit registers, word or byte access
// R02: internal ticks at clock /8, /64, /8192
// R03: external clock rising, falling or both edges
// R04: external clock pulses at least 1.5/2.5 clocks
// R05: capture pulses at least 1.5/2.5 clocks wide
// R06: match drives pin keep, 0, 1, toggle
// R07: clear counter on match A or B
// R08: clear counter on capture B
// R09: match fires when counter leaves matching value
// R10: capture copies counter to const B, sets flag
// R11: overflow flag on wrap ff to 00
// R12: pattern 100 in either channel cascades pair
// R13: even pattern 100: 16-bit, even is upper
// R14: even follows 16-bit matches, odd lower byte
// R15: 16-bit capture sets both B flags, even edge
// R16: 16-bit clear from even only, both bytes
// R17: even overflow on 16-bit wrap, odd own
// R18: odd pattern 100 counts even match A
// R19: odd capture disables even compare B
// R20: both cascade patterns stop the pair
// R21: 8-bit capture on odd own edge select
// R22: edge select 00 rise, 01 fall, 10 both
// R23: coinciding matches: toggle > 1 > 0 > keep
// R24: overflow clears by read one, write zero
// R25: upper byte counts on lower byte wrap
// R26: match flags clear like overflow flag
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"

module tmr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ext_clk_in,
  input wire logic [1:0] capture_io_in,
  output logic [1:0] capture_io_out,
  output logic [1:0] capture_io_oe,
  output logic [1:0] timer_out_pin,
  output logic [1:0] timer_out_en
);
  import tmr_pkg::*;

  // ****************************************************************
  // state and reset value
  // ****************************************************************
  localparam tmr_ch_t CH_RST = '{
    ctrl: `TMR_RST_CTRL,
    csr: `TMR_RST_CSR,
    cnt: `TMR_RST_CNT,
    cora: `TMR_RST_COR,
    corb: `TMR_RST_COR,
    arm: 3'h0,
    out: 1'b0,
    out_en: 1'b0
  };
  localparam tmr_state_t ST_RST = '{
    ch: '{CH_RST, CH_RST, CH_RST, CH_RST},
    prdata: 32'h0,
    pready: 1'b0,
    pslverr: 1'b0
  };

  tmr_state_t st_reg, st_next;
  tmr_apb_t bus;
  logic div8_tick, div64_tick, div8192_tick;
  logic [3:0] ext_rise, ext_fall;
  logic [1:0] cap_rise, cap_fall;
  logic [3:0] raw, tick, ma, mb, clr;
  logic [3:0] wr_ctrl, wr_csr, rd_csr, wr_cnt, wr_cora, wr_corb;
  logic [3:0][7:0] cnt_wd;
  logic [1:0] capt, m16;
  logic setup, acc_wr, acc_rd, hit_ch, hit_pair;
  logic [1:0] ach;
  logic [4:0] aofs;
  logic [31:0] rdata;

  assign bus = '{
    psel: psel,
    penable: penable,
    pwrite: pwrite,
    paddr: paddr,
    pwdata: pwdata,
    pstrb: pstrb
  };

  // ****************************************************************
  // prescaler and pin edge detectors
  // ****************************************************************
  tmr_prescale u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick8(div8_tick),
    .tick64(div64_tick),
    .tick8192(div8192_tick)
  );

  genvar gi;
  for (gi = 0; gi < 4; gi++)
  begin : g_ext
    tmr_edge u_ext (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(ext_clk_in[gi]),
      .rise(ext_rise[gi]),
      .fall(ext_fall[gi])
    );
  end

  for (gi = 0; gi < 2; gi++)
  begin : g_cap
    tmr_edge u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(capture_io_in[gi]),
      .rise(cap_rise[gi]),
      .fall(cap_fall[gi])
    );
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic src_tick(input logic [2:0] cks, input logic t8, t64, t8k,
                                    input logic er, ef);
    tmr_cks_t sel;
    sel = tmr_cks_t'(cks);
    case (sel)
      CKS_DIV8: src_tick = t8; // see R02
      CKS_DIV64: src_tick = t64; // see R02
      CKS_DIV8192: src_tick = t8k; // see R02
      CKS_EXT_RISE: src_tick = er; // see R03
      CKS_EXT_FALL: src_tick = ef; // see R03
      CKS_EXT_BOTH: src_tick = er | ef; // see R03
      default: src_tick = 1'b0;
    endcase
  endfunction : src_tick

  function automatic logic clr_hit(input logic [1:0] sel, input logic a, b, c);
    tmr_clr_t s;
    s = tmr_clr_t'(sel);
    case (s)
      CLR_MATCH_A: clr_hit = a; // see R07
      CLR_MATCH_B: clr_hit = b; // see R07
      CLR_CAPTURE: clr_hit = c; // see R08
      default: clr_hit = 1'b0;
    endcase
  endfunction : clr_hit

  function automatic logic cap_edge(input logic [1:0] sel, input logic r, f);
    case (sel)
      2'h0: cap_edge = r; // see R22
      2'h1: cap_edge = f; // see R22
      2'h2: cap_edge = r | f; // see R22
      default: cap_edge = 1'b0;
    endcase
  endfunction : cap_edge

  function automatic logic new_out(input logic a, b, input logic [1:0] oa, ob,
                                   input logic cur);
    logic [1:0] xa;
    logic [1:0] xb;
    tmr_act_t act;
    xa = a ? oa : 2'h0;
    xb = b ? ob : 2'h0;
    act = tmr_act_t'((xa > xb) ? xa : xb); // see R23
    case (act)
      ACT_LOW: new_out = 1'b0; // see R06
      ACT_HIGH: new_out = 1'b1; // see R06
      ACT_TOGGLE: new_out = ~cur; // see R06
      default: new_out = cur;
    endcase
  endfunction : new_out

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    tmr_ch_t ce;
    tmr_ch_t co;
    tmr_ch_t c;
    tmr_ch_t n;
    int e;
    int o;
    logic capture_enable;
    logic pulse_e;
    logic eq_a;
    logic eq_b;
    logic capb;
    logic [2:0] setf;
    logic [2:0] kill;
    ce = CH_RST;
    co = CH_RST;
    c = CH_RST;
    n = CH_RST;
    e = 0;
    o = 0;
    capture_enable = 1'b0;
    pulse_e = 1'b0;
    eq_a = 1'b0;
    eq_b = 1'b0;
    capb = 1'b0;
    setf = 3'h0;
    kill = 3'h0;
    st_next = st_reg;

    // bus decode, registers take one word, 8-bit data in low lane
    setup = bus.psel & ~bus.penable;
    ach = bus.paddr[6:5];
    aofs = bus.paddr[4:0];
    hit_pair = ({bus.paddr[7:3], 3'h0} == `TMR_OFS_PAIR_CNT) & (bus.paddr[1:0] == 2'h0);
    hit_ch = ~bus.paddr[7] & (aofs == `TMR_OFS_CTRL | aofs == `TMR_OFS_CSR |
      aofs == `TMR_OFS_CNT | aofs == `TMR_OFS_CORA | aofs == `TMR_OFS_CORB);
    acc_wr = bus.psel & bus.penable & st_reg.pready & bus.pwrite & ~st_reg.pslverr;
    acc_rd = bus.psel & bus.penable & st_reg.pready & ~bus.pwrite & ~st_reg.pslverr;

    for (int i = 0; i < 4; i++)
    begin
      wr_ctrl[i] = acc_wr & bus.pstrb[0] & hit_ch & (ach == 2'(i)) & (aofs == `TMR_OFS_CTRL);
      wr_csr[i] = acc_wr & bus.pstrb[0] & hit_ch & (ach == 2'(i)) & (aofs == `TMR_OFS_CSR);
      rd_csr[i] = acc_rd & hit_ch & (ach == 2'(i)) & (aofs == `TMR_OFS_CSR);
      wr_cora[i] = acc_wr & bus.pstrb[0] & hit_ch & (ach == 2'(i)) & (aofs == `TMR_OFS_CORA);
      wr_corb[i] = acc_wr & bus.pstrb[0] & hit_ch & (ach == 2'(i)) & (aofs == `TMR_OFS_CORB);
      // pair word: even byte in lane 1, odd byte in lane 0, each lane alone
      wr_cnt[i] = (acc_wr & bus.pstrb[0] & hit_ch & (ach == 2'(i)) & (aofs == `TMR_OFS_CNT)) |
        (acc_wr & hit_pair & (bus.paddr[2] == i[1]) & bus.pstrb[i[0] ? 0 : 1]); // see R01
      cnt_wd[i] = (hit_pair & ~i[0]) ? bus.pwdata[15:8] : bus.pwdata[7:0]; // see R01
    end

    // per pair: clock sources, cascade, matches, capture and clears
    for (int p = 0; p < 2; p++)
    begin
      e = 2 * p;
      o = e + 1;
      ce = st_reg.ch[e];
      co = st_reg.ch[o];
      raw[e] = src_tick(ce.ctrl[`TMR_CTRL_CKS], div8_tick, div64_tick, div8192_tick,
        ext_rise[e], ext_fall[e]);
      raw[o] = src_tick(co.ctrl[`TMR_CTRL_CKS], div8_tick, div64_tick, div8192_tick,
        ext_rise[o], ext_fall[o]);
      m16[p] = (ce.ctrl[`TMR_CTRL_CKS] == CKS_CASCADE) &
        (co.ctrl[`TMR_CTRL_CKS] != CKS_CASCADE); // see R12 R13 R20
      capture_enable = co.csr[`TMR_CSR_ICE];
      // upper byte steps on the lower byte's wrap
      tick[e] = m16[p] ? (raw[o] & (co.cnt == 8'hff)) : raw[e]; // see R13 R25
      pulse_e = m16[p] ? raw[o] : raw[e];
      eq_a = m16[p] ? ({ce.cnt, co.cnt} == {ce.cora, co.cora}) : (ce.cnt == ce.cora);
      eq_b = m16[p] ? ({ce.cnt, co.cnt} == {ce.corb, co.corb}) : (ce.cnt == ce.corb);
      // match fires on the step that leaves the equal value
      ma[e] = eq_a & pulse_e & ~wr_cora[e] & ~(m16[p] & wr_cora[o]); // see R09 R14
      mb[e] = eq_b & pulse_e & ~wr_corb[e] & ~(m16[p] & wr_corb[o]) & ~capture_enable; // see R09 R14 R19
      // odd counts even match A when only the odd picks the cascade
      tick[o] = ((co.ctrl[`TMR_CTRL_CKS] == CKS_CASCADE) &
        (ce.ctrl[`TMR_CTRL_CKS] != CKS_CASCADE)) ? ma[e] : raw[o]; // see R18 R20
      ma[o] = (co.cnt == co.cora) & tick[o] & ~wr_cora[o]; // see R09 R14
      mb[o] = (co.cnt == co.corb) & tick[o] & ~wr_corb[o] & ~capture_enable; // see R09 R14 R21
      capt[p] = capture_enable & cap_edge(m16[p] ? ce.csr[`TMR_CSR_OBS] : co.csr[`TMR_CSR_OBS],
        cap_rise[p], cap_fall[p]); // see R15 R21
      clr[e] = clr_hit(ce.ctrl[`TMR_CTRL_CLR], ma[e], mb[e], m16[p] & capt[p]);
      clr[o] = m16[p] ? clr[e] :
        clr_hit(co.ctrl[`TMR_CTRL_CLR], ma[o], mb[o], capt[p]); // see R16
    end

    // per channel: registers, flags and pin level
    for (int i = 0; i < 4; i++)
    begin
      c = st_reg.ch[i];
      n = c;
      capb = capt[i / 2] & (i[0] | m16[i / 2]); // see R15
      // clear beats a write, a write beats a step
      if (clr[i])
        n.cnt = 8'h00; // see R07 R08 R16
      else if (wr_cnt[i])
        n.cnt = cnt_wd[i];
      else if (tick[i])
        n.cnt = c.cnt + 8'h01;
      // capture keeps the value before any clear and beats a write
      if (capb)
        n.corb = c.cnt; // see R10
      else if (wr_corb[i])
        n.corb = bus.pwdata[7:0];
      if (wr_cora[i])
        n.cora = bus.pwdata[7:0];
      if (wr_ctrl[i])
        n.ctrl = bus.pwdata[7:0];
      // flags: hardware set wins over a clear in the same cycle
      setf = {mb[i] | capb, ma[i],
        tick[i] & (c.cnt == 8'hff) & ~clr[i] & ~wr_cnt[i]}; // see R10 R11 R15 R17
      kill = {3{wr_csr[i]}} & ~bus.pwdata[`TMR_CSR_FLAGS] & c.arm; // see R24 R26
      n.csr[`TMR_CSR_FLAGS] = setf | (c.csr[`TMR_CSR_FLAGS] & ~kill);
      if (wr_csr[i])
        n.csr[4:0] = bus.pwdata[4:0];
      // arm from the value the bus actually returned
      if (rd_csr[i])
        n.arm = st_reg.prdata[`TMR_CSR_FLAGS] | c.arm; // see R24 R26
      else if (wr_csr[i])
        n.arm = 3'h0;
      n.out = new_out(ma[i], mb[i], c.csr[`TMR_CSR_OAS], c.csr[`TMR_CSR_OBS], c.out);
      n.out_en = (|{n.csr[`TMR_CSR_OAS], n.csr[`TMR_CSR_OBS]}) & ~(i[0] & n.csr[`TMR_CSR_ICE]);
      st_next.ch[i] = n;
    end

    // read data caught in the setup cycle, answered in the first access cycle
    rdata = 32'h0;
    if (hit_pair)
      rdata = {16'h0, st_reg.ch[{bus.paddr[2], 1'b0}].cnt, st_reg.ch[{bus.paddr[2], 1'b1}].cnt};
    else if (hit_ch)
    begin
      case (aofs)
        `TMR_OFS_CTRL: rdata = {24'h0, st_reg.ch[ach].ctrl};
        `TMR_OFS_CSR: rdata = {24'h0, st_reg.ch[ach].csr};
        `TMR_OFS_CNT: rdata = {24'h0, st_reg.ch[ach].cnt};
        `TMR_OFS_CORA: rdata = {24'h0, st_reg.ch[ach].cora};
        `TMR_OFS_CORB: rdata = {24'h0, st_reg.ch[ach].corb};
        default: rdata = 32'h0;
      endcase
    end
    st_next.pready = setup;
    st_next.pslverr = setup & ~(hit_pair | hit_ch);
    if (setup)
      st_next.prdata = rdata;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign timer_out_pin = {st_reg.ch[2].out, st_reg.ch[0].out};
  assign timer_out_en = {st_reg.ch[2].out_en, st_reg.ch[0].out_en};
  assign capture_io_out = {st_reg.ch[3].out, st_reg.ch[1].out};
  assign capture_io_oe = {st_reg.ch[3].out_en, st_reg.ch[1].out_en};

endmodule : tmr_top
`default_nettype wire

// ==== pkg/tmr_defs.svh ====
// tmr_defs.svh: offsets, field positions, reset values and divider masks
// of the four-channel 8-bit timer; assumes a byte-addressed APB word map.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TMR_OFS_CTRL 5'h00
`define TMR_OFS_CSR 5'h04
`define TMR_OFS_CNT 5'h08
`define TMR_OFS_CORA 5'h0c
`define TMR_OFS_CORB 5'h10
`define TMR_CH_STRIDE 8'h20
`define TMR_OFS_PAIR_CNT 8'h80

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_CTRL_CKS 2:0
`define TMR_CTRL_CLR 4:3
`define TMR_CSR_FLAGS 7:5
`define TMR_CSR_ICE 4
`define TMR_CSR_OBS 3:2
`define TMR_CSR_OAS 1:0

// ****************************************************************
// reset values
// ****************************************************************
`define TMR_RST_CTRL 8'h00
`define TMR_RST_CSR 8'h00
`define TMR_RST_CNT 8'h00
`define TMR_RST_COR 8'hff

// ****************************************************************
// prescaler: divide by 8, 64 and 8192
// ****************************************************************
`define TMR_DIV_W 13
`define TMR_DIV8_MASK 13'h0007
`define TMR_DIV64_MASK 13'h003f
`define TMR_DIV8192_MASK 13'h1fff

`endif

// ==== pkg/tmr_pkg.sv ====
// tmr_pkg: types shared by the timer files.
// assumes tmr_defs.svh is on the include path.
`default_nettype none
`include "tmr_defs.svh"

package tmr_pkg;

  typedef enum logic [2:0] {
    CKS_STOP = 3'h0,
    CKS_DIV8 = 3'h1,
    CKS_DIV64 = 3'h2,
    CKS_DIV8192 = 3'h3,
    CKS_CASCADE = 3'h4,
    CKS_EXT_RISE = 3'h5,
    CKS_EXT_FALL = 3'h6,
    CKS_EXT_BOTH = 3'h7
  } tmr_cks_t;

  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_MATCH_A = 2'h1,
    CLR_MATCH_B = 2'h2,
    CLR_CAPTURE = 2'h3
  } tmr_clr_t;

  typedef enum logic [1:0] {
    ACT_KEEP = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } tmr_act_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tmr_apb_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] csr;
    logic [7:0] cnt;
    logic [7:0] cora;
    logic [7:0] corb;
    logic [2:0] arm;
    logic out;
    logic out_en;
  } tmr_ch_t;

  typedef struct packed {
    tmr_ch_t [3:0] ch;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmr_state_t;

  typedef struct packed {
    logic [`TMR_DIV_W-1:0] cnt;
    logic t8;
    logic t64;
    logic t8192;
  } tmr_div_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } tmr_edge_state_t;

endpackage : tmr_pkg
`default_nettype wire

// ==== testbench/tmr_host.sv ====
// tmr_host: apb master and pin source standing in for the cpu and board.
// assumes its tasks are called just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none

module tmr_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata,
  output var logic [3:0] pstrb,
  output var logic [3:0] ext_clk_in,
  output var logic [1:0] capture_drv
);
  import tmr_pkg::*;
  tmr_apb_t req;
  logic hung;
  assign {psel, penable, pwrite, paddr, pwdata, pstrb} = req;

  initial
  begin
    hung = 1'b0;
    req = '0;
    ext_clk_in = 4'h0;
    capture_drv = 2'h0;
  end

  // one apb transfer, held until pready is sampled high or 20 clocks pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d, {2'h0, w, w}};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    hung = (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {req.psel, req.penable} <= 2'b00;
  endtask : xfer

  // set a pin level and hold it six clocks
  task automatic pin(input int cap, input int i, input int v);
    @(posedge pclk);
    if (cap != 0)
      capture_drv[i] <= 1'(v);
    else
      ext_clk_in[i] <= 1'(v);
    repeat (6) @(posedge pclk);
  endtask : pin
endmodule : tmr_host

`default_nettype wire

// ==== testbench/tmr_tb.sv ====
// tmr_tb: self-checking bench for tmr_top driven through tmr_host.
// assumes tmr_pkg, tmr_host and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"

module testbench;
  import tmr_pkg::*;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, ext_clk_in;
  logic [1:0] cap_drv, capture_io_in, capture_io_out, capture_io_oe, timer_out_pin, timer_out_en;
  int errors = 0;
  int comparisons = 0;
  assign capture_io_in = (capture_io_oe & capture_io_out) | (~capture_io_oe & cap_drv);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  tmr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
    .capture_io_in(capture_io_in), .capture_io_out(capture_io_out),
    .capture_io_oe(capture_io_oe), .timer_out_pin(timer_out_pin),
    .timer_out_en(timer_out_en));
  tmr_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .ext_clk_in(ext_clk_in), .capture_drv(cap_drv));

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // channel 4 is the pair word of channels 0 and 1
  task automatic bus(input logic w, input int c, input logic [4:0] o, input logic [15:0] d);
    u_host.xfer(w, 8'(c * 32) | {3'h0, o}, {16'h0, d}, rdat, rerr);
    if (u_host.hung === 1'b1)
    begin
      errors++;
      print_verdict();
    end
  endtask : bus

  task automatic wr(input int c, input logic [4:0] o, input logic [15:0] d);
    bus(1'b1, c, o, d);
  endtask : wr

  task automatic rd(input int c, input logic [4:0] o, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    bus(1'b0, c, o, 16'h0);
    chk(rdat & m, e);
  endtask : rd

  task automatic t_reset();
    chk(32'({capture_io_out, capture_io_oe, timer_out_pin, timer_out_en}), 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      rd(c, `TMR_OFS_CTRL, 32'h0);
      rd(c, `TMR_OFS_CSR, 32'h0);
      rd(c, `TMR_OFS_CNT, 32'h0);
      rd(c, `TMR_OFS_CORA, 32'hff);
      rd(c, `TMR_OFS_CORB, 32'hff);
    end
    rd(0, 5'h14, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_match();
    wr(0, `TMR_OFS_CORA, 16'h5);
    wr(0, `TMR_OFS_CNT, 16'h5);
    wr(0, `TMR_OFS_CSR, 16'h3);
    repeat (20) @(posedge pclk);
    rd(0, `TMR_OFS_CSR, 32'h3);
    wr(0, `TMR_OFS_CTRL, 16'({CLR_MATCH_A, CKS_DIV8}));
    repeat (8) @(posedge pclk);
    rd(0, `TMR_OFS_CNT, 32'h0, 32'hfe);
    rd(0, `TMR_OFS_CSR, 32'h43);
    chk(32'(timer_out_pin[0]), 32'h1);
    chk(32'(timer_out_en[0]), 32'h1);
    wr(0, `TMR_OFS_CSR, 16'h3);
    rd(0, `TMR_OFS_CSR, 32'h3);
    wr(0, `TMR_OFS_CTRL, 16'h0);
    $display("test match done");
  endtask : t_match

  task automatic t_prio();
    wr(2, `TMR_OFS_CORA, 16'h3);
    wr(2, `TMR_OFS_CORB, 16'h3);
    for (int k = 0; k < 2; k++)
    begin
      wr(2, `TMR_OFS_CNT, 16'h3);
      wr(2, `TMR_OFS_CSR, k ? 16'h0e : 16'h09);
      wr(2, `TMR_OFS_CTRL, 16'(CKS_DIV8));
      repeat (12) @(posedge pclk);
      wr(2, `TMR_OFS_CTRL, 16'h0);
      chk(32'(timer_out_pin[1]), 32'(k == 0));
      rd(2, `TMR_OFS_CSR, k ? 32'hce : 32'hc9);
    end
    $display("test priority done");
  endtask : t_prio

  task automatic t_ovf();
    wr(1, `TMR_OFS_CNT, 16'hff);
    wr(1, `TMR_OFS_CTRL, 16'(CKS_DIV8));
    repeat (12) @(posedge pclk);
    wr(1, `TMR_OFS_CTRL, 16'h0);
    rd(1, `TMR_OFS_CNT, 32'h0, 32'hfe);
    wr(1, `TMR_OFS_CSR, 16'h0);
    rd(1, `TMR_OFS_CSR, 32'he0);
    wr(1, `TMR_OFS_CSR, 16'h0);
    rd(1, `TMR_OFS_CSR, 32'h0);
    wr(1, `TMR_OFS_CNT, 16'h0);
    wr(1, `TMR_OFS_CTRL, 16'(CKS_DIV64));
    repeat (147) @(posedge pclk);
    wr(1, `TMR_OFS_CTRL, 16'h0);
    rd(1, `TMR_OFS_CNT, 32'h2, 32'hfe);
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_cascade();
    wr(0, `TMR_OFS_CSR, 16'h0);
    wr(0, `TMR_OFS_CTRL, 16'(CKS_CASCADE));
    wr(4, 5'h0, 16'hffff);
    wr(1, `TMR_OFS_CTRL, 16'(CKS_EXT_RISE));
    u_host.pin(0, 1, 1);
    rd(4, 5'h0, 32'h0);
    rd(0, `TMR_OFS_CSR, 32'ha0);
    rd(1, `TMR_OFS_CSR, 32'he0);
    u_host.pin(0, 1, 0);
    wr(1, `TMR_OFS_CTRL, 16'(CKS_EXT_BOTH));
    u_host.pin(0, 1, 1);
    u_host.pin(0, 1, 0);
    wr(1, `TMR_OFS_CTRL, 16'(CKS_EXT_FALL));
    u_host.pin(0, 1, 1);
    u_host.pin(0, 1, 0);
    rd(4, 5'h0, 32'h3);
    wr(1, `TMR_OFS_CTRL, 16'h0);
    wr(0, `TMR_OFS_CTRL, 16'h0);
    $display("test cascade done");
  endtask : t_cascade

  task automatic t_capture();
    for (int m = 0; m < 3; m++)
    begin
      wr(3, `TMR_OFS_CSR, 16'(32'h10 + 4 * m));
      wr(3, `TMR_OFS_CNT, 16'(32'h10 + m));
      u_host.pin(1, 1, 1);
      rd(3, `TMR_OFS_CORB, m == 1 ? 32'h10 : 32'h10 + m);
      wr(3, `TMR_OFS_CNT, 16'(32'h20 + m));
      u_host.pin(1, 1, 0);
      rd(3, `TMR_OFS_CORB, m == 0 ? 32'h10 : 32'h20 + m);
    end
    rd(3, `TMR_OFS_CSR, 32'h80, 32'h80);
    chk(32'(capture_io_oe[1]), 32'h0);
    wr(3, `TMR_OFS_CTRL, 16'({CLR_CAPTURE, CKS_STOP}));
    wr(3, `TMR_OFS_CSR, 16'h10);
    wr(3, `TMR_OFS_CNT, 16'h33);
    u_host.pin(1, 1, 1);
    rd(3, `TMR_OFS_CNT, 32'h0);
    rd(3, `TMR_OFS_CORB, 32'h33);
    u_host.pin(1, 1, 0);
    wr(3, `TMR_OFS_CSR, 16'h0);
    $display("test capture done");
  endtask : t_capture

  task automatic t_count();
    wr(2, `TMR_OFS_CSR, 16'h0);
    wr(2, `TMR_OFS_CNT, 16'h0);
    wr(2, `TMR_OFS_CORA, 16'h0);
    wr(2, `TMR_OFS_CORB, 16'h0);
    wr(3, `TMR_OFS_CNT, 16'h0);
    wr(3, `TMR_OFS_CSR, 16'h10);
    // the even channel keeps its own clock, never both cascaded
    wr(3, `TMR_OFS_CTRL, 16'(CKS_CASCADE));
    wr(2, `TMR_OFS_CTRL, 16'({CLR_MATCH_A, CKS_EXT_RISE}));
    repeat (3)
    begin
      u_host.pin(0, 2, 1);
      u_host.pin(0, 2, 0);
    end
    rd(3, `TMR_OFS_CNT, 32'h3);
    rd(2, `TMR_OFS_CNT, 32'h0);
    rd(2, `TMR_OFS_CSR, 32'h40, 32'hc0);
    $display("test match count done");
  endtask : t_count

  initial
  begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_match();
    t_prio();
    t_ovf();
    t_cascade();
    t_capture();
    t_count();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire

// ==== testbench/tmr_top_asserts.sv ====
// tmr_top_asserts: port-level checks on the timer's bus and pins.
// assumes it is bound into tmr_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module tmr_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] timer_out_pin,
  input wire logic [1:0] capture_io_oe
);
  // ****************************************
  // bus handshake, read data and pins after reset
  // ****************************************
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read;
    pready && !pwrite;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_needs_setup: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  a_err_read_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  a_read_holds: assert property (s_read |=> $stable(prdata))
    else $error("read data moved");
  a_upper_zero: assert property (s_read |-> prdata[31:16] == 16'h0)
    else $error("unused read bits set");
  a_mapped_ok: assert property (pready && !paddr[7] && paddr[1:0] == 2'h0
    && paddr[4:0] <= 5'h10 |-> !pslverr)
    else $error("error on mapped register");
  a_hole_err: assert property (pready && paddr[4:0] == 5'h14 |-> pslverr)
    else $error("no error on hole");
  a_pins_reset: assert property ($rose(presetn) |-> timer_out_pin == 2'h0
    && capture_io_oe == 2'h0)
    else $error("pins not idle after reset");
endmodule : tmr_chk

bind tmr_top tmr_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_out_pin(timer_out_pin), .capture_io_oe(capture_io_oe)
);

`default_nettype wire
